// >>> src/system_bus_strobe_decode.sv
// Purpose: Drives external command strobes and ROM chip enables per cycle.
// Assumes: One cycle request at a time, held until cyc_done is returned.
// Notes:   Software reaches control and windows over APB.
//
// Behaviour
// [R1] Boot ROM select on unshadowed top-range reads.
// [R2] Either ROM enable via programmable extra windows.
// [R3] I/O read strobe during I/O reads.
// [R4] Option suppresses I/O read to internal devices.
// [R5] I/O write strobe during I/O writes.
// [R6] Option suppresses I/O write to internal devices.
// [R7] Memory read strobe, never for system RAM.
// [R8] Memory read strobe may be ROM output enable.
// [R9] Memory write strobe, never to RAM or ROM.
// [R10] Channel ready ORed with internal ready, waits.
// [R11] Width strap sizes boot ROM accesses.
// [R12] One strobe at most; idle between cycles.
`timescale 1ns/10ps

module system_bus_strobe_decode #(
  parameter int MIN_STROBE_CYCLES = 2
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire strobe_pkg::cyc_req_t cyc_req,
  input  wire logic                internal_ready,
  input  wire logic                channel_ready_in,
  input  wire logic                rom_width_strap,
  output logic                     cyc_done,
  output logic                     rom_is_8bit,
  output strobe_pkg::strobes_t     strobes
);

  // Elaboration check: the wait counter is four bits wide.
  if (MIN_STROBE_CYCLES < 1 || MIN_STROBE_CYCLES > 15) begin : g_bad_min
    $error("MIN_STROBE_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, win0_q, win0_d, win1_q, win1_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d, hit;
  logic        strap_q, strap_d, strap_seen_q, strap_seen_d;
  logic        width8_d;

  always_comb begin
    ctrl_d    = ctrl_q;
    win0_d    = win0_q;
    win1_d    = win1_q;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    pready_d  = 1'b0;
    hit = (paddr == strobe_pkg::CTRL_OFS) || (paddr == strobe_pkg::WIN0_OFS)
       || (paddr == strobe_pkg::WIN1_OFS)
       || (paddr == strobe_pkg::STATUS_OFS);
    if (psel && !penable) begin
      pready_d  = 1'b1;
      pslverr_d = !hit;
      prdata_d  = 32'h0000_0000;
      unique case (paddr)
        strobe_pkg::CTRL_OFS: prdata_d = ctrl_q;
        strobe_pkg::WIN0_OFS: prdata_d = win0_q;
        strobe_pkg::WIN1_OFS: prdata_d = win1_q;
        strobe_pkg::STATUS_OFS:
          prdata_d = {27'h0, strap_q, strobes.rom_chip_enable,
                      strobes.mem_read_strobe | strobes.mem_write_strobe,
                      strobes.io_read_strobe | strobes.io_write_strobe};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pready && pwrite && !pslverr) begin
      unique case (paddr)
        strobe_pkg::CTRL_OFS: ctrl_d = pwdata;
        strobe_pkg::WIN0_OFS: win0_d = pwdata;
        strobe_pkg::WIN1_OFS: win1_d = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= strobe_pkg::CTRL_RST;
      win0_q  <= strobe_pkg::WIN_RST;
      win1_q  <= strobe_pkg::WIN_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      win0_q  <= win0_d;
      win1_q  <= win1_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Width strap capture after reset release
  // ----------------------------------------------------------------------
  always_comb begin
    strap_seen_d = 1'b1;
    strap_d      = strap_seen_q ? strap_q : rom_width_strap;  // [R11]
    width8_d     = ctrl_q[strobe_pkg::CTRL_WIDTH] | strap_q;  // [R11]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strap_q      <= 1'b0;
      strap_seen_q <= 1'b0;
    end else begin
      strap_q      <= strap_d;
      strap_seen_q <= strap_seen_d;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic [7:0] page;
  logic       boot_hit, shadowed;
  logic [1:0] win_hit;
  logic       rom_access;
  logic [1:0] rce;
  strobe_pkg::strobes_t next_s;

  assign page     = cyc_req.addr[19:12];
  assign shadowed = ctrl_q[strobe_pkg::CTRL_SHADOW];
  assign boot_hit = (page >= strobe_pkg::BOOT_PAGE_LO)
                 && (page <= strobe_pkg::BOOT_PAGE_HI);

  // Each extra window maps its page range onto one ROM enable.
  for (genvar i = 0; i < 2; i++) begin : g_win
    logic [31:0] w;
    assign w = (i == 0) ? win0_q : win1_q;
    assign win_hit[i] = w[strobe_pkg::WIN_EN]
      && (page >= w[strobe_pkg::WIN_BASE_L +: 8])
      && (page <= w[strobe_pkg::WIN_LIM_L +: 8]);  // [R2]
  end

  always_comb begin
    rce = 2'b00;
    if (cyc_req.kind == strobe_pkg::CYC_MEM_RD && !cyc_req.sys_ram) begin
      rce[0] = (boot_hit && !shadowed) || win_hit[0];  // [R1] [R2]
      rce[1] = win_hit[1] && !rce[0];  // [R2]
    end
    rom_access = (boot_hit && !shadowed) || (|win_hit);
    next_s = '0;
    if (cyc_req.valid) begin
      next_s.rom_chip_enable = rce;
      unique case (cyc_req.kind)
        strobe_pkg::CYC_IO_RD:
          next_s.io_read_strobe = !(cyc_req.internal
            && ctrl_q[strobe_pkg::CTRL_IORD_SUPP]);  // [R3] [R4]
        strobe_pkg::CYC_IO_WR:
          next_s.io_write_strobe = !(cyc_req.internal
            && ctrl_q[strobe_pkg::CTRL_IOWR_SUPP]);  // [R5] [R6]
        strobe_pkg::CYC_MEM_RD:
          next_s.mem_read_strobe = !cyc_req.sys_ram && (!(|rce)
            || (ctrl_q[strobe_pkg::CTRL_OE_MODE]
                && rce[ctrl_q[strobe_pkg::CTRL_OE_SEL]]));  // [R7] [R8]
        strobe_pkg::CYC_MEM_WR:
          next_s.mem_write_strobe = !cyc_req.sys_ram
            && !rom_access;  // [R9]
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Cycle sequencer with wait states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_DONE   = 2'b10
  } state_t;

  state_t               state_q, state_d;
  logic [3:0]           cnt_q, cnt_d;
  strobe_pkg::strobes_t strobes_d;
  logic                 done_d, ready_any;

  assign ready_any = channel_ready_in | internal_ready;  // [R10]

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    strobes_d = strobes;
    done_d    = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        strobes_d = '0;  // [R12]
        if (cyc_req.valid) begin
          strobes_d = next_s;
          cnt_d     = 4'(MIN_STROBE_CYCLES - 1);
          state_d   = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (ready_any) begin  // [R10]
          strobes_d = '0;  // [R12]
          done_d    = 1'b1;
          state_d   = ST_DONE;
        end
      end
      ST_DONE: begin
        strobes_d = '0;
        if (!cyc_req.valid) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        strobes_d = '0;
        state_d   = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      strobes     <= '0;
      cyc_done    <= 1'b0;
      rom_is_8bit <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      strobes     <= strobes_d;
      cyc_done    <= done_d;
      rom_is_8bit <= width8_d;  // [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_ONE_STROBE: assert property (@(posedge sys_clk) disable iff (!rstn)
    $onehot0({strobes.io_read_strobe, strobes.io_write_strobe,
              strobes.mem_read_strobe, strobes.mem_write_strobe}))  // [R12]
    else $error("more than one command strobe active");
  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE |-> strobes == '0)  // [R12]
    else $error("strobes active while idle");
  AST_BOOT_CE: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && boot_hit && !shadowed
    && cyc_req.kind == strobe_pkg::CYC_MEM_RD && !cyc_req.sys_ram
    |=> strobes.rom_chip_enable[0])  // [R1]
    else $error("boot rom select missing");
  AST_NO_RAM_RD: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && cyc_req.sys_ram
    |=> !strobes.mem_read_strobe && !strobes.mem_write_strobe)  // [R7]
    else $error("memory strobe during system ram cycle");
  AST_IORD_SUPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && cyc_req.internal
    && ctrl_q[strobe_pkg::CTRL_IORD_SUPP]
    && cyc_req.kind == strobe_pkg::CYC_IO_RD
    |=> !strobes.io_read_strobe)  // [R4]
    else $error("io read strobe not suppressed");
  AST_IOWR_ON: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && !cyc_req.internal
    && cyc_req.kind == strobe_pkg::CYC_IO_WR
    |=> strobes.io_write_strobe)  // [R5]
    else $error("io write strobe missing");
  AST_WAIT: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_ACTIVE && cnt_q == 4'h0 && !ready_any
    |=> state_q == ST_ACTIVE && !cyc_done)  // [R10]
    else $error("cycle ended without ready");
  AST_ROM_WR: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && rom_access
    && cyc_req.kind == strobe_pkg::CYC_MEM_WR
    |=> !strobes.mem_write_strobe)  // [R9]
    else $error("memory write strobe to rom");
  AST_IORD_ON: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && !cyc_req.internal
    && cyc_req.kind == strobe_pkg::CYC_IO_RD
    |=> strobes.io_read_strobe)  // [R3]
    else $error("io read strobe missing");
  AST_IOWR_SUPP: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && cyc_req.internal
    && ctrl_q[strobe_pkg::CTRL_IOWR_SUPP]
    && cyc_req.kind == strobe_pkg::CYC_IO_WR
    |=> !strobes.io_write_strobe)  // [R6]
    else $error("io write strobe not suppressed");
  AST_WIN_CE: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && win_hit == 2'b10
    && !(boot_hit && !shadowed) && !cyc_req.sys_ram
    && cyc_req.kind == strobe_pkg::CYC_MEM_RD
    |=> strobes.rom_chip_enable == 2'b10)  // [R2]
    else $error("second rom enable missing");
  AST_ROM_OE: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && cyc_req.valid && !cyc_req.sys_ram
    && cyc_req.kind == strobe_pkg::CYC_MEM_RD
    && ctrl_q[strobe_pkg::CTRL_OE_MODE]
    && rce[ctrl_q[strobe_pkg::CTRL_OE_SEL]]
    |=> strobes.mem_read_strobe)  // [R8]
    else $error("rom output enable strobe missing");
  AST_WIDTH: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_q || ctrl_q[strobe_pkg::CTRL_WIDTH] |=> rom_is_8bit)  // [R11]
    else $error("rom width not reported");
  AST_DONE_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
    cyc_done |-> strobes == '0)  // [R12]
    else $error("strobes active after cycle end");

endmodule

// >>> pkg/strobe_pkg.sv
// Purpose: Shared constants and types for the system bus strobe decoder.
// Assumes: 20-bit real-mode physical addresses; APB data 32 bits wide.
// Notes:   Register offsets are byte addresses of aligned words.
package strobe_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] WIN0_OFS   = 8'h04;
  localparam logic [7:0] WIN1_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // Control bit positions.
  localparam int CTRL_SHADOW    = 0;
  localparam int CTRL_IORD_SUPP = 1;
  localparam int CTRL_IOWR_SUPP = 2;
  localparam int CTRL_OE_MODE   = 3;
  localparam int CTRL_OE_SEL    = 4;
  localparam int CTRL_WIDTH     = 5;

  // Window register fields: enable bit and 4 KiB page base/limit.
  localparam int WIN_EN     = 16;
  localparam int WIN_BASE_L = 0;
  localparam int WIN_LIM_L  = 8;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WIN_RST  = 32'h0000_0000;

  // Boot ROM range F000:0 to FFFF:F in physical pages.
  localparam logic [7:0] BOOT_PAGE_LO = 8'hF0;
  localparam logic [7:0] BOOT_PAGE_HI = 8'hFF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_IO_RD  = 2'b00,
    CYC_IO_WR  = 2'b01,
    CYC_MEM_RD = 2'b10,
    CYC_MEM_WR = 2'b11
  } cyc_kind_t;

  typedef struct packed {
    logic        valid;
    cyc_kind_t   kind;
    logic [19:0] addr;
    logic        internal;
    logic        sys_ram;
  } cyc_req_t;

  typedef struct packed {
    logic       io_read_strobe;
    logic       io_write_strobe;
    logic       mem_read_strobe;
    logic       mem_write_strobe;
    logic [1:0] rom_chip_enable;
  } strobes_t;

endpackage

// >>> testbench/ext_bus_model.sv
// Purpose: External I/O devices, expansion memory and boot ROM.
// Assumes: Ready is only offered while a strobe or ROM enable is active.
// Notes:   A nonzero stall holds ready low for that many cycles.
`timescale 1ns/10ps
module ext_bus_model (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire strobe_pkg::strobes_t strobes,
  input  wire logic [3:0]           stall,
  output logic                      channel_ready_in
);
  logic [3:0] cnt_q;

  // Devices answer a strobe, late when asked to stall.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (strobes == '0) begin
      cnt_q <= stall;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign channel_ready_in = (cnt_q == 4'h0) && (strobes != '0);
endmodule

// >>> testbench/system_bus_strobe_decode_tb.sv
// Purpose: Self-checking bench for the strobe decoder.
// Assumes: One bus cycle at a time; APB answers without wait states.
// Notes:   Expected strobes are queued by the driver, popped on done.
`timescale 1ns/10ps
module system_bus_strobe_decode_tb;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        internal_ready, channel_ready_in, rom_width_strap;
  logic        cyc_done, rom_is_8bit, e;
  logic [7:0]  paddr;
  logic [19:0] a;
  logic [31:0] pwdata, prdata, q, ctrl, w0, w1;
  logic [3:0]  stall;
  int          err_count, comparisons, ticks, n;
  strobe_pkg::cyc_req_t cyc_req;
  strobe_pkg::strobes_t strobes, seen;
  strobe_pkg::strobes_t exp_q[$];

  system_bus_strobe_decode system_bus_strobe_decode_i (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc_req(cyc_req),
    .internal_ready(internal_ready), .channel_ready_in(channel_ready_in),
    .rom_width_strap(rom_width_strap), .cyc_done(cyc_done),
    .rom_is_8bit(rom_is_8bit), .strobes(strobes));
  ext_bus_model ext_bus_model_i (.sys_clk(sys_clk), .rstn(rstn),
    .strobes(strobes), .stall(stall), .channel_ready_in(channel_ready_in));

  task automatic check(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cfg(input logic [31:0] c, x, y);
    ctrl = c;
    w0 = x;
    w1 = y;
    apb(1'b1, 8'h00, c);
    apb(1'b1, 8'h04, x);
    apb(1'b1, 8'h08, y);
  endtask

  // Expected strobes for one cycle under the current configuration.
  function automatic strobe_pkg::strobes_t want(input logic [1:0] k,
      input logic [19:0] ad, input logic in, ram);
    strobe_pkg::strobes_t s;
    logic [7:0] p;
    logic [1:0] r;
    p = ad[19:12];
    r = 2'b00;
    if (!ctrl[0] && p >= 8'hF0) r = 2'b01;
    else if (w0[16] && p >= w0[7:0] && p <= w0[15:8]) r = 2'b01;
    else if (w1[16] && p >= w1[7:0] && p <= w1[15:8]) r = 2'b10;
    if (ram) r = 2'b00;
    s.io_read_strobe = k == 2'd0 && !(in && ctrl[1]);
    s.io_write_strobe = k == 2'd1 && !(in && ctrl[2]);
    s.mem_read_strobe = k == 2'd2 && !ram &&
                        (r == 2'b00 || (ctrl[3] && r[ctrl[4]]));
    s.mem_write_strobe = k == 2'd3 && !ram && r == 2'b00;
    s.rom_chip_enable = (k == 2'd2) ? r : 2'b00;
    return s;
  endfunction

  task automatic cyc(input logic [1:0] k, input logic [19:0] ad,
                     input logic in, ram);
    exp_q.push_back(want(k, ad, in, ram));
    cyc_req <= '{1'b1, strobe_pkg::cyc_kind_t'(k), ad, in, ram};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cyc_done !== 1'b1);
    cyc_req.valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (cyc_done === 1'b1)
      check(32'(seen), 32'(exp_q.pop_front()), "strb");
    seen = strobes;
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cyc_req, rom_width_strap, stall, ctrl, w0, w1} = '0;
    internal_ready = 1'b1;
    void'($urandom(32'hB747));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(32'(strobes), 32'h0, "idle");
    for (int i = 0; i < 20; i += 4) begin
      apb(1'b1, 8'h0C, 32'hFFFFFFFF);
      apb(1'b0, 8'(i), 32'h0);
      check(q, 32'h0, "reg");
      check(32'(e), 32'(i == 16), "err");
    end
    $display("registers done");
    rom_width_strap <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(32'(rom_is_8bit), 32'h0, "strap");
    cfg(32'h20, 32'h0, 32'h0);
    check(32'(rom_is_8bit), 32'h1, "width");
    apb(1'b0, 8'h00, 32'h0);
    check(q, 32'h20, "ctrl");
    for (int i = 0; i < 32; i++) begin
      cfg(32'(i[4:3]) << 1, 32'h0, 32'h0);
      cyc(i[1:0], 20'($urandom_range(20'hEFFFF)), i[2], 1'b0);
    end
    cyc(2'd2, 20'h12345, 1'b0, 1'b1);
    cyc(2'd3, 20'h2A000, 1'b0, 1'b1);
    $display("strobe table done");
    a = 20'hF0000 | 20'($urandom_range(20'hFFFF));
    cyc(2'd2, a, 1'b0, 1'b0);
    cyc(2'd2, 20'hFFFFF, 1'b0, 1'b0);
    cyc(2'd2, 20'hEFFFF, 1'b0, 1'b0);
    cyc(2'd3, a, 1'b0, 1'b0);
    cfg(32'h1, 32'h0, 32'h0);
    cyc(2'd2, a, 1'b0, 1'b0);
    $display("boot rom done");
    cfg(32'h0, 32'h12F20, 32'h13F28);
    for (int i = 0; i < 4; i++) begin
      cfg(32'(i) << 3, w0, w1);
      cyc(2'd2, 20'h25000, 1'b0, 1'b0);
      cyc(2'd2, 20'h3F000, 1'b0, 1'b0);
    end
    cyc(2'd2, 20'h2A000, 1'b0, 1'b0);
    cyc(2'd2, 20'h40000, 1'b0, 1'b0);
    cyc(2'd3, 20'h30000, 1'b0, 1'b0);
    $display("windows done");
    internal_ready <= 1'b0;
    stall <= 4'h6;
    cyc(2'd0, 20'h00300, 1'b0, 1'b0);
    check(32'(n > 6), 32'h1, "slow");
    internal_ready <= 1'b1;
    cyc(2'd1, 20'h00300, 1'b0, 1'b0);
    check(32'(n > 6), 32'h0, "fast");
    $display("ready done");
    rstn <= 1'b0;
    {ctrl, w0, w1} = '0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(32'(rom_is_8bit), 32'h1, "strap");
    cyc(2'd2, a, 1'b0, 1'b0);
    check(32'(exp_q.size()), 32'h0, "queue");
    $display("reset done");
    close_out();
  end
endmodule
